// file: sfbf_top.v
// Fractional baud divider and FIFO configuration logic of a serial channel, with APB registers.
// Assumes the shift engines and FIFO fill-level logic run on pclk and drive the event inputs.
//
// Summary of operation
// - The fraction register holds a four-bit K from 1 to 15, and zero is not a legal value; the code accepts zero, its reset value, and then divides by N + 1.
// - With fractional divide off or outside UART mode the generator divides by N, otherwise by N + (16 - K)/16 on average.
// - With the FIFO enabled, duplex mode sizes the FIFOs to 4 receive, 4 transmit, or 2 plus 2 bytes.
// - The receive usage select limits the receive FIFO to the full depth or the interrupt fill level.
// - The transmit FIFO always offers its full configured depth.
// - With the FIFO enabled, transmit interrupts pass only while their FIFO enable bit is set.
// - With the FIFO enabled, receive interrupts pass only while their FIFO enable bit is set.
// - Auto-disable in half-duplex receive clears the receive enable on the stop condition.
// - Auto-disable in half-duplex transmit clears the transmit enable when the FIFO runs empty.
// - Auto-disable in full duplex clears both enables when either condition occurs.
//
// Chosen here: the APB slave port and the register offsets.
`default_nettype none
`include "sfbf_defines.vh"

module sfbf_top (
    input wire pclk,
    input wire presetn,
    input wire pclk_en,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire prescale_tick,
    input wire rx_stop_event,
    input wire tx_fifo_empty,
    input wire rx_irq_req,
    input wire tx_irq_req,
    input wire [1:0] rx_fill_level,
    output wire baud_tick,
    output wire rx_enable,
    output wire tx_enable,
    output wire fifo_enable,
    output wire [2:0] rx_fifo_depth,
    output wire [2:0] tx_fifo_depth,
    output wire [2:0] rx_fifo_usable,
    output wire rx_irq,
    output wire tx_irq,
    output wire irq
);
    // ======================================================================
    // Helpers
    // Depth that one FIFO gets from the duplex code; used for both directions.
    function [2:0] fifo_depth;
        input [1:0] dpx;
        input is_rx;
        begin
            case (dpx)
                `SFBF_DPX_HALF_RX: fifo_depth = is_rx ? `SFBF_DEPTH_HALF : `SFBF_DEPTH_NONE;
                `SFBF_DPX_HALF_TX: fifo_depth = is_rx ? `SFBF_DEPTH_NONE : `SFBF_DEPTH_HALF;
                `SFBF_DPX_FULL: fifo_depth = `SFBF_DEPTH_FULL;
                default: fifo_depth = `SFBF_DEPTH_NONE;
            endcase
        end
    endfunction

    function addr_mapped;
        input [7:0] a;
        begin
            case (a)
                `SFBF_OFF_BAUD, `SFBF_OFF_FRAC, `SFBF_OFF_FCNF, `SFBF_OFF_MODE,
                `SFBF_OFF_STAT, `SFBF_OFF_ISTAT, `SFBF_OFF_ICLR, `SFBF_OFF_IEN: addr_mapped = 1'b1;
                default: addr_mapped = 1'b0;
            endcase
        end
    endfunction

    // ======================================================================
    // Declarations
    reg [3:0] n_q;
    reg frac_en_q;
    reg [3:0] k_q;
    reg [7:0] fcnf_q;
    reg rxe_q;
    reg txe_q;
    reg [1:0] dpx_q;
    reg uart_q;
    reg [`SFBF_IRQ_W-1:0] ien_q;
    reg [31:0] prdata_q;
    reg [31:0] rdata_d;
    reg tx_empty_q;
    reg rx_irq_q;
    reg tx_irq_q;
    reg [2:0] rxd_q;
    reg [2:0] txd_q;
    reg [2:0] rxu_q;
    reg rxe_d;
    reg txe_d;
    wire wr_en;
    wire setup;
    wire cnfg;
    wire auto_on;
    wire rx_cond;
    wire tx_cond;
    wire clr_rx;
    wire clr_tx;
    wire [2:0] rxd_d;
    wire [2:0] txd_d;
    wire [2:0] rxu_d;
    wire rx_irq_d;
    wire tx_irq_d;
    wire [`SFBF_IRQ_W-1:0] irq_events;
    wire [`SFBF_IRQ_W-1:0] irq_status;
    wire iclr_wr;

    // ======================================================================
    // APB handshake
    // Stalling the access while the clock enable is low keeps writes and state frozen together.
    assign pready = pclk_en;
    assign setup = psel && !penable;
    assign wr_en = psel && penable && pwrite && pclk_en && addr_mapped(paddr);
    assign pslverr = psel && penable && !addr_mapped(paddr);
    assign iclr_wr = wr_en && (paddr == `SFBF_OFF_ICLR);

    // ======================================================================
    // Configuration registers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            n_q <= 4'h0;
            frac_en_q <= 1'b0;
            k_q <= 4'h0;
            fcnf_q <= `SFBF_FCNF_RESET;
            dpx_q <= 2'b00;
            uart_q <= 1'b0;
            ien_q <= {`SFBF_IRQ_W{1'b0}};
        end else if (wr_en) begin
            case (paddr)
                `SFBF_OFF_BAUD: begin
                    n_q <= pwdata[`SFBF_BAUD_N_MSB:`SFBF_BAUD_N_LSB];
                    frac_en_q <= pwdata[`SFBF_BAUD_FRAC_EN];
                end
                `SFBF_OFF_FRAC: k_q <= pwdata[`SFBF_K_MSB:`SFBF_K_LSB];
                `SFBF_OFF_FCNF: fcnf_q <= pwdata[`SFBF_FCNF_RW_MSB:0];
                `SFBF_OFF_MODE: begin
                    dpx_q <= pwdata[`SFBF_MODE_DPX_MSB:`SFBF_MODE_DPX_LSB];
                    uart_q <= pwdata[`SFBF_MODE_UART];
                end
                `SFBF_OFF_IEN: ien_q <= pwdata[`SFBF_IRQ_W-1:0];
                default: ;
            endcase
        end
    end

    assign cnfg = fcnf_q[`SFBF_FCNF_CNFG];

    // ======================================================================
    // Auto-disable of the transmit and receive enables
    // Only the empty edge counts, so enabling transmit with an empty FIFO does not clear itself at once.
    assign auto_on = cnfg && fcnf_q[`SFBF_FCNF_AUTO];
    assign rx_cond = rx_stop_event;
    assign tx_cond = tx_fifo_empty && !tx_empty_q;
    assign clr_rx = auto_on && (((dpx_q == `SFBF_DPX_HALF_RX) && rx_cond) ||
                                ((dpx_q == `SFBF_DPX_FULL) && (rx_cond || tx_cond)));
    assign clr_tx = auto_on && (((dpx_q == `SFBF_DPX_HALF_TX) && tx_cond) ||
                                ((dpx_q == `SFBF_DPX_FULL) && (rx_cond || tx_cond)));

    always @* begin
        rxe_d = rxe_q;
        txe_d = txe_q;
        if (wr_en && (paddr == `SFBF_OFF_MODE)) begin
            rxe_d = pwdata[`SFBF_MODE_RXE];
            txe_d = pwdata[`SFBF_MODE_TXE];
        end
        // The hardware stop beats a software write in the same cycle.
        if (clr_rx) begin
            rxe_d = 1'b0;
        end
        if (clr_tx) begin
            txe_d = 1'b0;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rxe_q <= 1'b0;
            txe_q <= 1'b0;
            tx_empty_q <= 1'b1;
        end else if (pclk_en) begin
            rxe_q <= rxe_d;
            txe_q <= txe_d;
            tx_empty_q <= tx_fifo_empty;
        end
    end

    // ======================================================================
    // FIFO sizing and interrupt gating
    // A usage limit of zero would leave no room, so code zero keeps the full depth.
    // The limit never exceeds the configured depth, so a missing receive FIFO stays at zero.
    assign rxd_d = cnfg ? fifo_depth(dpx_q, 1'b1) : `SFBF_DEPTH_NONE;
    assign txd_d = cnfg ? fifo_depth(dpx_q, 1'b0) : `SFBF_DEPTH_NONE;
    assign rxu_d = (fcnf_q[`SFBF_FCNF_RX_FIFO_USAGE_SELECT] && (rx_fill_level != 2'b00) && ({1'b0, rx_fill_level} < rxd_d)) ?
                   {1'b0, rx_fill_level} : rxd_d;
    assign rx_irq_d = rx_irq_req && (!cnfg || fcnf_q[`SFBF_FCNF_RX_FIFO_IRQ_ENABLE]);
    assign tx_irq_d = tx_irq_req && (!cnfg || fcnf_q[`SFBF_FCNF_TX_FIFO_IRQ_ENABLE]);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rxd_q <= `SFBF_DEPTH_NONE;
            txd_q <= `SFBF_DEPTH_NONE;
            rxu_q <= `SFBF_DEPTH_NONE;
            rx_irq_q <= 1'b0;
            tx_irq_q <= 1'b0;
        end else if (pclk_en) begin
            rxd_q <= rxd_d;
            txd_q <= txd_d;
            rxu_q <= rxu_d;
            rx_irq_q <= rx_irq_d;
            tx_irq_q <= tx_irq_d;
        end
    end

    // ======================================================================
    // Read data
    always @* begin
        rdata_d = 32'h0000_0000;
        case (paddr)
            `SFBF_OFF_BAUD: begin
                rdata_d[`SFBF_BAUD_N_MSB:`SFBF_BAUD_N_LSB] = n_q;
                rdata_d[`SFBF_BAUD_FRAC_EN] = frac_en_q;
            end
            `SFBF_OFF_FRAC: rdata_d[`SFBF_K_MSB:`SFBF_K_LSB] = k_q;
            `SFBF_OFF_FCNF: rdata_d = `SFBF_FCNF_FIXED | {24'h00_0000, fcnf_q};
            `SFBF_OFF_MODE: begin
                rdata_d[`SFBF_MODE_RXE] = rxe_q;
                rdata_d[`SFBF_MODE_TXE] = txe_q;
                rdata_d[`SFBF_MODE_DPX_MSB:`SFBF_MODE_DPX_LSB] = dpx_q;
                rdata_d[`SFBF_MODE_UART] = uart_q;
            end
            `SFBF_OFF_STAT: begin
                rdata_d[`SFBF_STAT_RXD_LSB+2:`SFBF_STAT_RXD_LSB] = rxd_q;
                rdata_d[`SFBF_STAT_RXU_LSB+2:`SFBF_STAT_RXU_LSB] = rxu_q;
                rdata_d[`SFBF_STAT_TXD_LSB+2:`SFBF_STAT_TXD_LSB] = txd_q;
            end
            `SFBF_OFF_ISTAT: rdata_d[`SFBF_IRQ_W-1:0] = irq_status;
            `SFBF_OFF_IEN: rdata_d[`SFBF_IRQ_W-1:0] = ien_q;
            default: rdata_d = 32'h0000_0000;
        endcase
    end

    // Read data is captured in the setup cycle, so the access phase answers from a flip-flop.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
        end else if (pclk_en && setup) begin
            prdata_q <= pwrite ? 32'h0000_0000 : rdata_d;
        end
    end

    // ======================================================================
    // Baud generator
    // Fractional divide is held off outside UART mode even if software sets the bit.
    sfbf_baud u_baud (
        .pclk(pclk),
        .presetn(presetn),
        .ce(pclk_en),
        .prescale_tick(prescale_tick),
        .n_code(n_q),
        .k_code(k_q),
        .frac_en(frac_en_q && uart_q),
        .baud_tick(baud_tick)
    );

    // ======================================================================
    // Interrupts
    assign irq_events[`SFBF_IRQ_RX] = rx_irq_d;
    assign irq_events[`SFBF_IRQ_TX] = tx_irq_d;
    assign irq_events[`SFBF_IRQ_ADRX] = clr_rx && rxe_q;
    assign irq_events[`SFBF_IRQ_ADTX] = clr_tx && txe_q;

    sfbf_irq #(
        .W(`SFBF_IRQ_W)
    ) u_irq (
        .pclk(pclk),
        .presetn(presetn),
        .ce(pclk_en),
        .events(irq_events),
        .clr_wr(iclr_wr),
        .clr_data(pwdata[`SFBF_IRQ_W-1:0]),
        .enable(ien_q),
        .status(irq_status),
        .irq(irq)
    );

    // ======================================================================
    // Outputs
    assign prdata = prdata_q;
    assign rx_enable = rxe_q;
    assign tx_enable = txe_q;
    assign fifo_enable = cnfg;
    assign rx_fifo_depth = rxd_q;
    assign tx_fifo_depth = txd_q;
    assign rx_fifo_usable = rxu_q;
    assign rx_irq = rx_irq_q;
    assign tx_irq = tx_irq_q;
endmodule // sfbf_top
`default_nettype wire

// file: sfbf_defines.vh
// Constants shared by the fractional baud divider and FIFO configuration block.
// Assumes a 32-bit APB register bus with byte addresses in the low eight bits.
`ifndef SFBF_DEFINES_VH
`define SFBF_DEFINES_VH

// ==========================================================================
// Register byte offsets
`define SFBF_OFF_BAUD 8'h00
`define SFBF_OFF_FRAC 8'h04
`define SFBF_OFF_FCNF 8'h08
`define SFBF_OFF_MODE 8'h0C
`define SFBF_OFF_STAT 8'h10
`define SFBF_OFF_ISTAT 8'h14
`define SFBF_OFF_ICLR 8'h18
`define SFBF_OFF_IEN 8'h1C

// ==========================================================================
// Baud control fields
`define SFBF_BAUD_N_MSB 3
`define SFBF_BAUD_N_LSB 0
`define SFBF_BAUD_FRAC_EN 6
`define SFBF_K_MSB 3
`define SFBF_K_LSB 0
`define SFBF_N_ZERO_DIV 5'h10
`define SFBF_FRAC_ONE 5'h10

// ==========================================================================
// FIFO configuration fields
`define SFBF_FCNF_CNFG 0
`define SFBF_FCNF_AUTO 1
`define SFBF_FCNF_RX_FIFO_IRQ_ENABLE 2
`define SFBF_FCNF_TX_FIFO_IRQ_ENABLE 3
`define SFBF_FCNF_RX_FIFO_USAGE_SELECT 4
`define SFBF_FCNF_RW_MSB 7
`define SFBF_FCNF_RESET 8'h00
`define SFBF_FCNF_FIXED 32'h0000_0600

// ==========================================================================
// Channel mode fields and duplex codes
`define SFBF_MODE_RXE 0
`define SFBF_MODE_TXE 1
`define SFBF_MODE_DPX_MSB 3
`define SFBF_MODE_DPX_LSB 2
`define SFBF_MODE_UART 4
`define SFBF_DPX_HALF_RX 2'b01
`define SFBF_DPX_HALF_TX 2'b10
`define SFBF_DPX_FULL 2'b11

// ==========================================================================
// FIFO depths in bytes
`define SFBF_DEPTH_HALF 3'h4
`define SFBF_DEPTH_FULL 3'h2
`define SFBF_DEPTH_NONE 3'h0

// ==========================================================================
// Status field positions and interrupt bits
`define SFBF_STAT_RXD_LSB 0
`define SFBF_STAT_RXU_LSB 4
`define SFBF_STAT_TXD_LSB 8
`define SFBF_IRQ_W 4
`define SFBF_IRQ_RX 0
`define SFBF_IRQ_TX 1
`define SFBF_IRQ_ADRX 2
`define SFBF_IRQ_ADTX 3

`endif

// file: sfbf_baud.v
// Baud generator: divides prescaler ticks by N, or by N + (16 - K)/16.
// Assumes prescale_tick is a one-cycle pulse from logic on the same clock.
`default_nettype none
`include "sfbf_defines.vh"

module sfbf_baud (
    input wire pclk,
    input wire presetn,
    input wire ce,
    input wire prescale_tick,
    input wire [3:0] n_code,
    input wire [3:0] k_code,
    input wire frac_en,
    output wire baud_tick
);
    reg [4:0] cnt_q;
    reg [3:0] acc_q;
    reg stretch_q;
    reg tick_q;
    wire [4:0] n_eff;
    wire [4:0] period;
    wire [4:0] frac_add;
    wire [4:0] acc_sum;
    wire wrap;

    // ======================================================================
    // Period selection
    // Code zero divides by sixteen.
    assign n_eff = (n_code == 4'h0) ? `SFBF_N_ZERO_DIV : {1'b0, n_code};
    // Each period adds 16 - K; a carry stretches the next period by one tick.
    assign frac_add = `SFBF_FRAC_ONE - {1'b0, k_code};
    assign acc_sum = {1'b0, acc_q} + frac_add;
    assign period = n_eff + {4'h0, stretch_q};
    // A shorter N written mid-period must not let the counter run past the new end.
    assign wrap = (cnt_q >= (period - 5'h01));

    // ======================================================================
    // Counter
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 5'h00;
            acc_q <= 4'h0;
            stretch_q <= 1'b0;
            tick_q <= 1'b0;
        end else if (ce) begin
            tick_q <= 1'b0;
            if (prescale_tick) begin
                if (wrap) begin
                    cnt_q <= 5'h00;
                    tick_q <= 1'b1;
                    if (frac_en) begin
                        acc_q <= acc_sum[3:0];
                        stretch_q <= acc_sum[4];
                    end else begin
                        acc_q <= 4'h0;
                        stretch_q <= 1'b0;
                    end
                end else begin
                    cnt_q <= cnt_q + 5'h01;
                end
            end
        end
    end

    assign baud_tick = tick_q;
endmodule // sfbf_baud
`default_nettype wire

// file: sfbf_irq.v
// Sticky interrupt status with write-one-to-clear and an enable mask.
// Assumes events are one-cycle pulses on the same clock.
`default_nettype none

module sfbf_irq #(
    parameter W = 4
) (
    input wire pclk,
    input wire presetn,
    input wire ce,
    input wire [W-1:0] events,
    input wire clr_wr,
    input wire [W-1:0] clr_data,
    input wire [W-1:0] enable,
    output wire [W-1:0] status,
    output wire irq
);
    reg [W-1:0] status_q;
    genvar i;

    // ======================================================================
    // Status bits
    // A new event wins over a clear in the same cycle so it is never lost.
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    status_q[i] <= 1'b0;
                end else if (ce) begin
                    if (events[i]) begin
                        status_q[i] <= 1'b1;
                    end else if (clr_wr && clr_data[i]) begin
                        status_q[i] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    assign status = status_q;
    assign irq = |(status_q & enable);
endmodule // sfbf_irq
`default_nettype wire

// file: sfbf_props.sv
// Concurrent checks on the ports of the serial divider and FIFO configuration block.
// Assumes a bind to sfbf_top, with one clock and an asynchronous low reset.
`default_nettype none
module sfbf_props (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pclk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic prescale_tick,
    input wire logic rx_stop_event,
    input wire logic tx_fifo_empty,
    input wire logic rx_irq_req,
    input wire logic tx_irq_req,
    input wire logic baud_tick,
    input wire logic rx_enable,
    input wire logic tx_enable,
    input wire logic fifo_enable,
    input wire logic [2:0] rx_fifo_depth,
    input wire logic [2:0] tx_fifo_depth,
    input wire logic [2:0] rx_fifo_usable,
    input wire logic rx_irq,
    input wire logic tx_irq
);
    // ==========================================================================
    // Checks
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire wr = psel && penable && pwrite;
    a_depth_off: assert property (!fifo_enable && $past(!fifo_enable) |->
        rx_fifo_depth == 3'h0 && tx_fifo_depth == 3'h0 && rx_fifo_usable == 3'h0) else $error("depth while off");
    a_depth_legal: assert property (rx_fifo_depth inside {3'h0, 3'h2, 3'h4} &&
        {1'b0, rx_fifo_depth} + {1'b0, tx_fifo_depth} <= 4'h4) else $error("illegal fifo sizes");
    a_usable_le: assert property (rx_fifo_usable <= rx_fifo_depth) else $error("usable above depth");
    a_rx_irq_cause: assert property (rx_irq && $past(pclk_en) |-> $past(rx_irq_req)) else $error("rx irq uncaused");
    a_tx_irq_cause: assert property (tx_irq && $past(pclk_en) |-> $past(tx_irq_req)) else $error("tx irq uncaused");
    a_irq_pass_off: assert property (rx_irq_req && pclk_en && !fifo_enable |=> rx_irq) else $error("rx irq lost");
    a_txen_fall: assert property ($fell(tx_enable) |->
        $past(wr) || $past(fifo_enable) && $past(tx_fifo_empty || rx_stop_event)) else $error("tx enable dropped");
    a_rxen_fall: assert property ($fell(rx_enable) |->
        $past(wr) || $past(fifo_enable) && $past(rx_stop_event || tx_fifo_empty)) else $error("rx enable dropped");
    a_baud_cause: assert property (baud_tick && $past(pclk_en) |-> $past(prescale_tick)) else $error("stray tick");
    c_tx_auto: cover property ($fell(tx_enable));
    c_rx_auto: cover property ($fell(rx_enable));
    c_rx_irq: cover property (rx_irq && fifo_enable);
endmodule // sfbf_props
bind sfbf_top sfbf_props u_props (.pclk(pclk), .presetn(presetn), .pclk_en(pclk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .prescale_tick(prescale_tick), .rx_stop_event(rx_stop_event),
    .tx_fifo_empty(tx_fifo_empty), .rx_irq_req(rx_irq_req), .tx_irq_req(tx_irq_req), .baud_tick(baud_tick),
    .rx_enable(rx_enable), .tx_enable(tx_enable), .fifo_enable(fifo_enable), .rx_fifo_depth(rx_fifo_depth),
    .tx_fifo_depth(tx_fifo_depth), .rx_fifo_usable(rx_fifo_usable), .rx_irq(rx_irq), .tx_irq(tx_irq));
`default_nettype wire

// file: sfbf_peer.sv
// Serial peer model: prescaler ticks and a transmit FIFO that drains one byte per baud period.
// Assumes the bench loads a byte count with a one-cycle strobe on pclk.
`default_nettype none
module sfbf_peer (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [1:0] tick_gap,
    input wire logic load,
    input wire logic [2:0] load_cnt,
    input wire logic baud_tick,
    output logic prescale_tick,
    output logic tx_fifo_empty
);
    // ==========================================================================
    // Ticks and transmit drain
    logic [1:0] gap_q;
    logic [2:0] cnt_q;
    // Empty only once the last byte has left, so a load of one or more bytes makes one rising edge.
    assign tx_fifo_empty = (cnt_q == 3'h0);
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap_q <= 2'h0;
            cnt_q <= 3'h0;
            prescale_tick <= 1'b0;
        end else begin
            prescale_tick <= (gap_q == 2'h0);
            gap_q <= (gap_q == 2'h0) ? tick_gap : gap_q - 2'h1;
            if (load) begin
                cnt_q <= load_cnt;
            end else if (baud_tick && !tx_fifo_empty) begin
                cnt_q <= cnt_q - 3'h1;
            end
        end
    end
endmodule // sfbf_peer
`default_nettype wire

// file: sfbf_tb_top.sv
// Self-checking bench for the serial divider and FIFO configuration block.
// Assumes sfbf_top with its checker bound in and the serial peer model beside it.
`default_nettype none
`include "sfbf_defines.vh"
module sfbf_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk, presetn, pclk_en, psel, penable, pwrite, rx_stop_event, rx_irq_req, tx_irq_req, load;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [1:0] rx_fill_level, tick_gap;
    logic [2:0] load_cnt;
    wire [31:0] prdata;
    wire pready, pslverr, prescale_tick, tx_fifo_empty, baud_tick, rx_enable, tx_enable, fifo_enable;
    wire rx_irq, tx_irq, irq;
    wire [2:0] rx_fifo_depth, tx_fifo_depth, rx_fifo_usable;
    logic [32:0] exp_q[$];
    int n_mismatch, total_checks, cyc, n, k, m;
    int st_tab[4] = '{0, 'h044, 'h400, 'h222};
    int ad_dpx[5] = '{1, 2, 3, 3, 3};
    int ad_trg[5] = '{0, 1, 0, 1, 0};
    int ad_cnf[5] = '{1, 1, 1, 1, 0};
    int ad_exp[5] = '{1, 2, 0, 0, 3};

    sfbf_top dut (.pclk, .presetn, .pclk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .prescale_tick, .rx_stop_event, .tx_fifo_empty, .rx_irq_req, .tx_irq_req, .rx_fill_level,
        .baud_tick, .rx_enable, .tx_enable, .fifo_enable, .rx_fifo_depth, .tx_fifo_depth, .rx_fifo_usable,
        .rx_irq, .tx_irq, .irq);
    sfbf_peer peer (.pclk, .presetn, .tick_gap, .load, .load_cnt, .baud_tick, .prescale_tick, .tx_fifo_empty);

    // ==========================================================================
    // Clock, timeout and checking
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            n_mismatch++;
            report_and_stop();
        end
        if (psel && penable && pready && !pwrite) begin
            chk("prdata", exp_q.pop_front(), {pslverr, prdata});
        end
    end
    task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] g);
        total_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // ==========================================================================
    // Bus and event drivers
    // A stall drops pclk_en during the access phase; the master simply waits for pready.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e, input int st);
        if (!w) exp_q.push_back(e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        if (st != 0) begin
            pclk_en <= 1'b0;
            repeat (st) @(posedge pclk);
            pclk_en <= 1'b1;
        end
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input int d);
        xfer(1'b1, a, 32'(d), 33'h0, 0);
    endtask
    task automatic rd(input logic [7:0] a, input int d);
        xfer(1'b0, a, 32'h0000_0000, {1'b0, 32'(d)}, 0);
    endtask
    task automatic pulse(input int which);
        @(posedge pclk);
        case (which)
            0: rx_irq_req <= 1'b1;
            1: tx_irq_req <= 1'b1;
            default: rx_stop_event <= 1'b1;
        endcase
        @(posedge pclk);
        rx_irq_req <= 1'b0;
        tx_irq_req <= 1'b0;
        rx_stop_event <= 1'b0;
        @(negedge pclk);
    endtask
    task automatic measure(output int cnt);
        cnt = 0;
        repeat (2) begin
            do @(posedge pclk); while (baud_tick !== 1'b1);
        end
        repeat (16) begin
            do begin
                @(posedge pclk);
                cnt++;
            end while (baud_tick !== 1'b1);
        end
    endtask

    // ==========================================================================
    // Scenarios
    initial begin
        {psel, penable, pwrite, rx_stop_event, rx_irq_req, tx_irq_req, load} = '0;
        {paddr, pwdata, rx_fill_level, tick_gap, load_cnt} = '0;
        {n_mismatch, total_checks, cyc} = '0;
        pclk_en = 1'b1;
        presetn = 1'b0;
        void'($urandom(7148));
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 9; i++) xfer(1'b0, 8'(4 * i), 0, {i == 8, (i == 2) ? 32'h0000_0600 : 32'h0}, i % 2);
        wr(`SFBF_OFF_STAT, 'hFFFF);
        wr(`SFBF_OFF_FCNF, 'h1E);
        rd(`SFBF_OFF_FCNF, 'h61E);
        rx_fill_level <= 2'($urandom % 3 + 1);
        for (int i = 0; i < 8; i++) begin
            wr(`SFBF_OFF_MODE, (i % 4) << 2);
            wr(`SFBF_OFF_FCNF, (i / 4) | ((i % 4 == 2) ? 'h10 : 0));
            repeat (3) @(posedge pclk);
            rd(`SFBF_OFF_STAT, (i / 4) ? st_tab[i % 4] : 0);
        end
        wr(`SFBF_OFF_MODE, 'h4);
        wr(`SFBF_OFF_FCNF, 'h11);
        repeat (3) @(posedge pclk);
        rd(`SFBF_OFF_STAT, 'h4 | (rx_fill_level << 4));
        chk("usable", 33'(rx_fill_level), 33'(rx_fifo_usable));
        wr(`SFBF_OFF_FCNF, 0);
        for (int i = 0; i < 3; i++) begin
            n = (i == 0) ? 0 : $urandom % 14 + 2;
            k = $urandom % 15 + 1;
            tick_gap <= 2'($urandom % 2);
            wr(`SFBF_OFF_FRAC, k);
            rd(`SFBF_OFF_FRAC, k);
            wr(`SFBF_OFF_MODE, 'h10);
            wr(`SFBF_OFF_BAUD, n | ((i == 2) << 6));
            measure(m);
            chk("baud", 33'((tick_gap + 1) * (16 * (n ? n : 16) + ((i == 2) ? 16 - k : 0))), 33'(m));
        end
        wr(`SFBF_OFF_IEN, 'hF);
        pulse(0);
        chk("irq", 33'h3, {rx_irq, irq});
        rd(`SFBF_OFF_ISTAT, 1);
        wr(`SFBF_OFF_ICLR, 1);
        rd(`SFBF_OFF_ISTAT, 0);
        wr(`SFBF_OFF_IEN, 0);
        pulse(1);
        chk("masked", 33'h2, {tx_irq, irq});
        wr(`SFBF_OFF_ICLR, 'hF);
        wr(`SFBF_OFF_MODE, 'hC);
        for (int j = 0; j < 4; j++) begin
            wr(`SFBF_OFF_FCNF, 1 | ((j % 2) << ((j / 2) ? 3 : 2)));
            pulse(j / 2);
            chk("fifo_irq", 33'(j % 2), (j / 2) ? tx_irq : rx_irq);
        end
        wr(`SFBF_OFF_BAUD, 2);
        for (int c = 0; c < 5; c++) begin
            wr(`SFBF_OFF_MODE, 3 | (ad_dpx[c] << 2));
            wr(`SFBF_OFF_FCNF, 2 | ad_cnf[c]);
            if (ad_trg[c]) begin
                load_cnt <= 3'($urandom % 4 + 1);
                load <= 1'b1;
                @(posedge pclk);
                load <= 1'b0;
                repeat (60) @(posedge pclk);
            end else begin
                pulse(2);
            end
            repeat (2) @(posedge pclk);
            chk("enables", 33'(ad_exp[c]), {rx_enable, tx_enable});
        end
        report_and_stop();
    end
endmodule // sfbf_tb_top
`default_nettype wire
